// ---- rps_consts.svh ----
// Constants for the reset and power-mode sequencer
`ifndef RPS_CONSTS_SVH
`define RPS_CONSTS_SVH
// Reset sequence length in TCL, and TCL per CPU clock
`define RPS_SEQ_TCL 1024
`define RPS_TCL_PER_CLK 2
// Width of the sequence counter
`define RPS_CNT_W 10
// System configuration word and position of the bidirectional reset enable
`define RPS_CFG_W 16
`define RPS_BDR_BIT 3
// Reset values of the synchronised pins: reset pin, programming voltage, ready
`define RPS_PIN_RST 3'h0
`endif

// ---- rps_pkg.sv ----
// Types shared by the reset and power-mode sequencer
package rps_pkg;

  // Sequencer states; codes 9 to 15 are illegal
  typedef enum logic [3:0] {
    ST_RUN     = 4'h0,
    ST_HOLD    = 4'h1,
    ST_TRANS   = 4'h2,
    ST_WDTBUS  = 4'h3,
    ST_SEQ     = 4'h4,
    ST_EXTEND  = 4'h5,
    ST_PMDRAIN = 4'h6,
    ST_IDLE    = 4'h7,
    ST_PDOWN   = 4'h8
  } rps_state_type;

  // Cause of the last reset
  typedef enum logic [1:0] {
    SRC_POR  = 2'h0,
    SRC_WARM = 2'h1,
    SRC_SOFT = 2'h2,
    SRC_WDT  = 2'h3
  } rps_src_type;

  // Status of the external bus controller
  typedef struct packed {
    logic busCycleActive;
    logic busUsesReady;
    logic waitStatesDone;
  } rps_bus_type;

  // Power-mode configuration
  typedef struct packed {
    logic readyEnable;
    logic readyPolarity;
    logic pdFastWake;
  } rps_pm_cfg_type;

endpackage

// ---- rps_sync2.sv ----
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rps_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arstN,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [1:0][W-1:0] stQ;
  logic [1:0][W-1:0] stD;

  // First stage feeds only the second
  always_comb begin
    stD = {stQ[0], d};
  end

  // Both stages take the reset constant
  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      stQ <= {RST_VAL, RST_VAL};
    end else begin
      stQ <= stD;
    end
  end

  assign q = stQ[1];

endmodule

// ---- rps_sequencer.sv ----
// Reset and power-mode sequencer
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Reset entry is asynchronous; pin release is synchronised before leaving reset.
// - Reset pin latched low with programming-voltage pin high starts a warm reset.
// - Warm reset entry floats all I/O at once and pulls reset output low.
// - After pin release, cancel holds, finish internal accesses, abort external cycles.
// - Then the internal reset sequence runs 1024 TCL, 512 clock cycles.
// - With bidirectional reset enabled, drive reset pin low during the sequence.
// - Every reset sequence ends by clearing the bidirectional reset enable.
// - At sequence end, hold internal reset while the reset pin stays low.
// - The software reset instruction starts the reset sequence at any time.
// - Software reset with bidirectional enable drives the pin low for 1024 TCL.
// - Watchdog overflow starts the reset sequence.
// - Watchdog reset completes a bus cycle without ready or with ready active.
// - Watchdog reset aborts a bus cycle whose ready is inactive after waitstates.
// - Watchdog reset is suppressed in bootstrap loader mode.
// - Bidirectional reset shows watchdog and software resets on the pin.
// - Idle halts the CPU only; any reset or interrupt ends it.
// - Power-down halts everything; ends by hardware reset or fast interrupt.
// - Idle and power-down wait until external bus actions are finished.
// - Entry is refused if ready enabled but not active on last access.
// - Watchdog overflow also pulls the reset output pin low.
//////////////////////////////////////////////////////////////////////////////
`include "rps_consts.svh"
`timescale 1ns/1ps
module rps_sequencer #(
  parameter logic [`RPS_CNT_W-1:0] SEQ_CYCLES =
    (`RPS_CNT_W)'(`RPS_SEQ_TCL / `RPS_TCL_PER_CLK)
) (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic nrst,
  // Reset pins
  input wire logic rstInPinIn,
  output logic rstInPinOut,
  output logic rstInPinOe,
  output logic rstOutPinN,
  input wire logic vppPinIn,
  // Reset triggers
  input wire logic softResetExec,
  input wire logic wdtOverflow,
  input wire logic bootstrapMode,
  // System configuration
  input wire logic sysCfgWrEn,
  input wire logic [`RPS_CFG_W-1:0] sysCfgWrData,
  output logic bidirResetEnable,
  // External bus
  input wire rps_pkg::rps_bus_type busIn,
  input wire logic readyPinIn,
  input wire logic intAccessBusy,
  output logic holdCancel,
  output logic busAbort,
  // Power modes
  input wire logic idleReq,
  input wire logic pdReq,
  input wire rps_pkg::rps_pm_cfg_type pmCfg,
  input wire logic intReq,
  input wire logic fastIntReq,
  output logic pmRefused,
  output logic cpuHalt,
  output logic periphHalt,
  // Status
  output logic intReset,
  output logic ioHighZ,
  output rps_pkg::rps_src_type resetSource
);
  import rps_pkg::*;

  localparam logic [`RPS_CNT_W-1:0] SEQ_LAST = SEQ_CYCLES - (`RPS_CNT_W)'(1);

  typedef struct packed {
    rps_state_type state;
    rps_src_type src;
    logic [`RPS_CNT_W-1:0] cnt;
    logic bdr;
    logic drive;
    logic pmIsPd;
    logic lastReadyOk;
    logic holdCancel;
    logic busAbort;
    logic pmRefused;
    logic intReset;
    logic cpuHalt;
    logic periphHalt;
  } rps_seq_type;

  typedef struct packed {
    logic ioHighZ;
    logic rstOutN;
  } rps_pin_type;

  rps_seq_type q;
  rps_seq_type d;
  rps_pin_type pq;
  rps_pin_type pd;
  logic arstN;
  logic pinArstN;
  logic [2:0] pinSync;
  logic pinHigh;
  logic vppHigh;
  logic readySync;
  logic readyActive;
  logic warmHit;
  logic wdtHit;
  logic pmReq;
  logic seqExit;

  //////////////////////////////////////////////////////////////////////////
  // Asynchronous reset entry; our own pin drive is masked so a soft
  // bidirectional reset does not reset the sequencer that makes it
  assign pinArstN = nrst & (rstInPinIn | q.drive);
  assign arstN = nrst & (rstInPinIn | vppPinIn | q.drive);

  // Pins cross into the clock domain before the next-state logic reads them; the reset gating above reads them raw
  rps_sync2 #(
    .W(3),
    .RST_VAL(`RPS_PIN_RST)
  ) u_sync (
    .clk(clk),
    .arstN(arstN),
    .d({rstInPinIn, vppPinIn, readyPinIn}),
    .q(pinSync)
  );

  // Decoded trigger conditions
  assign pinHigh = pinSync[2];
  assign vppHigh = pinSync[1];
  assign readySync = pinSync[0];
  assign readyActive = (readySync == pmCfg.readyPolarity);
  assign warmHit = !pinHigh && vppHigh && !q.drive;
  assign wdtHit = wdtOverflow && !bootstrapMode;
  assign pmReq = idleReq || pdReq;
  assign seqExit = (q.cnt == SEQ_LAST);

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    d = q;
    d.holdCancel = 1'b0;
    d.busAbort = 1'b0;
    d.pmRefused = 1'b0;
    // Ready outcome of the last access that used the handshake
    if (busIn.busCycleActive && busIn.busUsesReady && busIn.waitStatesDone) begin
      d.lastReadyOk = readyActive;
    end
    // Software writes are only possible while internal reset is inactive
    if (sysCfgWrEn && !q.intReset) begin
      d.bdr = sysCfgWrData[`RPS_BDR_BIT];
    end
    unique case (q.state)
      ST_RUN, ST_PMDRAIN: begin
        if (warmHit) begin
          d.state = ST_HOLD;
          d.src = SRC_WARM;
        end else if (softResetExec) begin
          d.state = ST_TRANS;
          d.src = SRC_SOFT;
        end else if (wdtHit) begin
          d.state = ST_WDTBUS;
          d.src = SRC_WDT;
        end else if (q.state == ST_RUN && pmReq) begin
          if (pmCfg.readyEnable && !q.lastReadyOk) begin
            d.pmRefused = 1'b1;
          end else begin
            d.state = ST_PMDRAIN;
            d.pmIsPd = pdReq;
          end
        end else if (q.state == ST_PMDRAIN && !busIn.busCycleActive) begin
          d.state = q.pmIsPd ? ST_PDOWN : ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (warmHit) begin
          d.state = ST_HOLD;
          d.src = SRC_WARM;
        end else if (wdtHit) begin
          d.state = ST_WDTBUS;
          d.src = SRC_WDT;
        end else if (intReq) begin
          d.state = ST_RUN;
        end
      end
      ST_PDOWN: begin
        // Watchdog is stopped with the peripherals
        if (warmHit) begin
          d.state = ST_HOLD;
          d.src = SRC_WARM;
        end else if (pmCfg.pdFastWake && fastIntReq) begin
          d.state = ST_RUN;
        end
      end
      ST_HOLD: begin
        // Leave only once the synchronised pin is released
        if (pinHigh) begin
          d.state = ST_TRANS;
        end
      end
      ST_TRANS: begin
        d.holdCancel = 1'b1;
        d.busAbort = 1'b1;
        if (!intAccessBusy) begin
          d.state = ST_SEQ;
          d.cnt = '0;
          d.drive = q.bdr;
        end
      end
      ST_WDTBUS: begin
        if (!busIn.busCycleActive) begin
          d.state = ST_SEQ;
          d.cnt = '0;
          d.drive = q.bdr;
        end else if (busIn.busUsesReady && busIn.waitStatesDone && !readyActive) begin
          d.busAbort = 1'b1;
          d.state = ST_SEQ;
          d.cnt = '0;
          d.drive = q.bdr;
        end
      end
      ST_SEQ: begin
        d.cnt = q.cnt + (`RPS_CNT_W)'(1);
        if (seqExit) begin
          d.state = ST_EXTEND;
          d.bdr = 1'b0;
          d.drive = 1'b0;
        end
      end
      ST_EXTEND: begin
        // Prolonged while anyone still holds the pin low
        if (pinHigh) begin
          d.state = ST_RUN;
        end
      end
      default: begin
        d.state = ST_HOLD;
      end
    endcase
    d.intReset = (d.state == ST_HOLD) || (d.state == ST_TRANS) || (d.state == ST_WDTBUS)
      || (d.state == ST_SEQ) || (d.state == ST_EXTEND);
    d.cpuHalt = d.intReset || (d.state == ST_IDLE) || (d.state == ST_PDOWN);
    d.periphHalt = (d.state == ST_PDOWN);
  end

  // Pin-facing flags follow the internal reset
  always_comb begin
    pd.ioHighZ = d.intReset;
    pd.rstOutN = !d.intReset;
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer state; comes out of reset waiting for the pin release
  always_ff @(posedge clk or negedge arstN) begin
    if (!arstN) begin
      q <= '{state: ST_HOLD, src: SRC_POR, cnt: '0, bdr: 1'b0, drive: 1'b0,
             pmIsPd: 1'b0, lastReadyOk: 1'b1, holdCancel: 1'b0, busAbort: 1'b0,
             pmRefused: 1'b0, intReset: 1'b1, cpuHalt: 1'b1, periphHalt: 1'b0};
    end else begin
      q <= d;
    end
  end

  // Separate flops so a warm reset floats the I/O without a clock edge
  always_ff @(posedge clk or negedge pinArstN) begin
    if (!pinArstN) begin
      pq <= '{ioHighZ: 1'b1, rstOutN: 1'b0};
    end else begin
      pq <= pd;
    end
  end

  // Outputs
  assign rstInPinOut = 1'b0;
  assign rstInPinOe = q.drive;
  assign rstOutPinN = pq.rstOutN;
  assign ioHighZ = pq.ioHighZ;
  assign bidirResetEnable = q.bdr;
  assign holdCancel = q.holdCancel;
  assign busAbort = q.busAbort;
  assign pmRefused = q.pmRefused;
  assign cpuHalt = q.cpuHalt;
  assign periphHalt = q.periphHalt;
  assign intReset = q.intReset;
  assign resetSource = q.src;

  //////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arstN);

  property p_seq_len;
    (q.state == ST_SEQ && q.cnt != SEQ_LAST) |=> (q.state == ST_SEQ);
  endproperty
  a_seq_len: assert property (p_seq_len) else $error("sequence left early");

  property p_seq_end;
    (q.state == ST_SEQ && seqExit) |=> (q.state == ST_EXTEND && !bidirResetEnable && !rstInPinOe);
  endproperty
  a_seq_end: assert property (p_seq_end) else $error("bdr not cleared at end");

  property p_bdr_drive;
    $rose(q.state == ST_SEQ) && $past(q.bdr) |-> rstInPinOe [*8];
  endproperty
  a_bdr_drive: assert property (p_bdr_drive) else $error("reset pin not driven");

  property p_extend;
    (q.state == ST_EXTEND && !pinHigh) |=> intReset && q.state == ST_EXTEND;
  endproperty
  a_extend: assert property (p_extend) else $error("reset not prolonged");

  property p_soft;
    (q.state == ST_RUN && softResetExec && !warmHit) |=> (q.state == ST_TRANS) ##1 holdCancel;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset not started");

  property p_boot;
    (q.state == ST_RUN && wdtOverflow && bootstrapMode && !softResetExec && !warmHit)
      |=> !intReset;
  endproperty
  a_boot: assert property (p_boot) else $error("watchdog reset in bootstrap");

  property p_wdt_abort;
    (q.state == ST_WDTBUS && busIn.busCycleActive && busIn.busUsesReady
      && busIn.waitStatesDone && !readyActive) |=> busAbort && q.state == ST_SEQ;
  endproperty
  a_wdt_abort: assert property (p_wdt_abort) else $error("bus cycle not aborted");

  property p_wdt_keep;
    (q.state == ST_WDTBUS && busIn.busCycleActive
      && !(busIn.busUsesReady && busIn.waitStatesDone && !readyActive))
      |=> !busAbort && q.state == ST_WDTBUS;
  endproperty
  a_wdt_keep: assert property (p_wdt_keep) else $error("bus cycle not completed");

  property p_refuse;
    (q.state == ST_RUN && pmReq && pmCfg.readyEnable && !q.lastReadyOk && !warmHit
      && !softResetExec && !wdtHit) |=> pmRefused && !cpuHalt;
  endproperty
  a_refuse: assert property (p_refuse) else $error("power mode not refused");

  property p_drain;
    (q.state == ST_PMDRAIN && busIn.busCycleActive && !warmHit && !softResetExec
      && !wdtHit) |=> !cpuHalt;
  endproperty
  a_drain: assert property (p_drain) else $error("halted with bus busy");

  property p_idle_wake;
    (q.state == ST_IDLE && intReq && !warmHit && !wdtHit) |=> !cpuHalt && q.state == ST_RUN;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle not ended");

  property p_wdt_out;
    (q.state == ST_WDTBUS) |-> !rstOutPinN && ioHighZ;
  endproperty
  a_wdt_out: assert property (p_wdt_out) else $error("reset output not low");

  c_soft_seq: cover property ((q.state == ST_SEQ) && seqExit && q.src == SRC_SOFT);
  c_wdt_abort: cover property ((q.state == ST_WDTBUS) ##1 busAbort);
  c_idle: cover property ((q.state == ST_IDLE) ##1 (q.state == ST_RUN));
  c_pd_wake: cover property ((q.state == ST_PDOWN) ##1 (q.state == ST_RUN));

endmodule

// ---- rps_board_model.sv ----
// Board-side reset circuit: pulled-up reset pin and programming pin
`timescale 1ns/1ps
module rps_board_model (
  // Device drive of the reset pin
  input wire logic rstInPinOut,
  input wire logic rstInPinOe,
  // Board stimulus
  input wire logic extLow,
  input wire logic vppHigh,
  // Levels seen by the device
  output logic rstInPinIn,
  output logic vppPinIn
);
  // Wired-AND with pull-up, so a released pin reads high, never a stale value
  assign rstInPinIn = !((rstInPinOe && !rstInPinOut) || extLow);
  assign vppPinIn = vppHigh;
endmodule

// ---- rps_sequencer_test.sv ----
// Self-checking bench for the reset and power-mode sequencer
`timescale 1ns/1ps
module rps_sequencer_test;
  import rps_pkg::*;
  // Short sequence keeps the run brief
  localparam logic [9:0] SEQ = 10'h008;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic extLow = 1'b0;
  logic vppHigh = 1'b1;
  logic softResetExec = 1'b0;
  logic wdtOverflow = 1'b0;
  logic bootstrapMode = 1'b0;
  logic sysCfgWrEn = 1'b0;
  logic [15:0] sysCfgWrData = 16'h0000;
  rps_bus_type busIn = 3'h0;
  logic readyPinIn = 1'b0;
  logic intAccessBusy = 1'b0;
  logic idleReq = 1'b0;
  logic pdReq = 1'b0;
  rps_pm_cfg_type pmCfg = 3'h0;
  logic intReq = 1'b0;
  logic fastIntReq = 1'b0;
  logic rstInPinIn, rstInPinOut, rstInPinOe, rstOutPinN, vppPinIn, bidirResetEnable;
  logic holdCancel, busAbort, pmRefused, cpuHalt, periphHalt, intReset, ioHighZ;
  rps_src_type resetSource;
  int n_errors = 0;
  int n_tests = 0;
  int n;
  logic [15:0] oeCnt = 16'h0000;
  logic [15:0] lfsr = 16'h002C;

  ////////////////////////////////////////////////////////////////
  // Device and board
  rps_sequencer #(.SEQ_CYCLES(SEQ)) i_dut (
    .clk, .nrst, .rstInPinIn, .rstInPinOut, .rstInPinOe, .rstOutPinN, .vppPinIn,
    .softResetExec, .wdtOverflow, .bootstrapMode, .sysCfgWrEn, .sysCfgWrData,
    .bidirResetEnable, .busIn, .readyPinIn, .intAccessBusy, .holdCancel, .busAbort,
    .idleReq, .pdReq, .pmCfg, .intReq, .fastIntReq, .pmRefused, .cpuHalt,
    .periphHalt, .intReset, .ioHighZ, .resetSource
  );
  rps_board_model i_board (.rstInPinOut, .rstInPinOe, .extLow, .vppHigh, .rstInPinIn,
    .vppPinIn);

  // 40 MHz clock
  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic pick(input int k);
    case (k)
      0: return intReset;
      1: return busAbort;
      2: return pmRefused;
      3: return cpuHalt;
      4: return periphHalt;
      default: return holdCancel;
    endcase
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bounded wait at falling edges; also counts cycles of own pin drive
  task automatic waitFor(input int k, input logic v, input int maxc, output int cnt);
    cnt = 0;
    while (pick(k) !== v && cnt < maxc) begin
      if (rstInPinOe === 1'b1) oeCnt++;
      @(negedge clk);
      cnt++;
    end
    check({15'h0000, pick(k)}, {15'h0000, v});
  endtask

  task automatic settle(input rps_src_type src);
    @(negedge clk);
    waitFor(0, 1'b0, 60, n);
    check(16'(n >= SEQ), 16'h0001);
    check({14'h0000, resetSource}, {14'h0000, src});
  endtask

  // One-cycle request: 0 software reset, 1 watchdog, 2 idle, 3 power-down
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: softResetExec <= 1'b1;
      1: wdtOverflow <= 1'b1;
      2: idleReq <= 1'b1;
      default: pdReq <= 1'b1;
    endcase
    @(posedge clk);
    {softResetExec, wdtOverflow, idleReq, pdReq} <= 4'h0;
    @(negedge clk);
  endtask

  // Random upper bits prove only the enable bit is kept
  task automatic writeCfg(input logic bdr);
    lfsr = nextRand(lfsr);
    @(posedge clk);
    sysCfgWrEn <= 1'b1;
    sysCfgWrData <= {lfsr[15:4], bdr, lfsr[2:0]};
    @(posedge clk);
    sysCfgWrEn <= 1'b0;
    @(negedge clk);
    check(16'(bidirResetEnable), {15'h0000, bdr});
  endtask

  task automatic runReset(input int k, input logic bdr);
    writeCfg(bdr);
    pulse(k);
    waitFor(0, 1'b1, 4, n);
    check(16'({ioHighZ, rstOutPinN, cpuHalt}), 16'h0005);
    oeCnt = 16'h0000;
    settle(k == 0 ? SRC_SOFT : SRC_WDT);
    check(oeCnt, bdr ? {6'h00, SEQ} : 16'h0000);
    check(16'(bidirResetEnable), 16'h0000);
  endtask

  // Bus access that updates the ready history
  task automatic busAccess();
    repeat (3) @(posedge clk);
    busIn <= 3'h7;
    repeat (2) @(posedge clk);
    busIn <= 3'h0;
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  // Main sequence
  initial begin
    repeat (7) @(posedge clk);
    @(negedge clk);
    check(16'({intReset, cpuHalt, ioHighZ, rstOutPinN, rstInPinOe, bidirResetEnable}),
      16'h0038);
    @(posedge clk);
    nrst <= 1'b1;
    settle(SRC_POR);
    // Pin reset with programming pin low acts without a clock edge
    @(posedge clk);
    vppHigh <= 1'b0;
    extLow <= 1'b1;
    #2;
    check(16'(intReset), 16'h0001);
    repeat (3) @(posedge clk);
    extLow <= 1'b0;
    vppHigh <= 1'b1;
    settle(SRC_POR);
    // Hand-picked then random software and watchdog resets
    runReset(0, 1'b1);
    runReset(0, 1'b0);
    runReset(1, 1'b1);
    for (int i = 0; i < 6; i++) begin
      lfsr = nextRand(lfsr);
      runReset(int'(lfsr[1]), lfsr[0]);
    end
    // Watchdog blocked in bootstrap mode
    @(posedge clk);
    bootstrapMode <= 1'b1;
    pulse(1);
    repeat (4) @(negedge clk);
    check(16'(intReset), 16'h0000);
    @(posedge clk);
    bootstrapMode <= 1'b0;
    // Watchdog while a bus cycle waits on an inactive ready
    readyPinIn <= 1'b1;
    busIn <= 3'h7;
    repeat (3) @(posedge clk);
    pulse(1);
    waitFor(1, 1'b1, 6, n);
    @(posedge clk);
    busIn <= 3'h0;
    settle(SRC_WDT);
    // Watchdog while a bus cycle with active ready runs on
    @(posedge clk);
    readyPinIn <= 1'b0;
    busIn <= 3'h7;
    repeat (3) @(posedge clk);
    pulse(1);
    repeat (10) begin
      @(negedge clk);
      check(16'({busAbort, intReset}), 16'h0001);
    end
    @(posedge clk);
    busIn <= 3'h0;
    settle(SRC_WDT);
    // Warm reset; a busy internal access stretches the transition
    @(posedge clk);
    extLow <= 1'b1;
    intAccessBusy <= 1'b1;
    #2;
    check(16'({ioHighZ, rstOutPinN}), 16'h0002);
    repeat (6) @(negedge clk);
    check(16'(intReset), 16'h0001);
    @(posedge clk);
    extLow <= 1'b0;
    @(negedge clk);
    waitFor(5, 1'b1, 6, n);
    check(16'(busAbort), 16'h0001);
    repeat (5) @(negedge clk);
    check(16'(holdCancel), 16'h0001);
    @(posedge clk);
    intAccessBusy <= 1'b0;
    settle(SRC_WARM);
    // Idle refused after a ready access with ready inactive
    @(posedge clk);
    pmCfg <= 3'h4;
    readyPinIn <= 1'b1;
    busAccess();
    pulse(2);
    waitFor(2, 1'b1, 3, n);
    check(16'(cpuHalt), 16'h0000);
    // Idle waits for the running bus cycle, interrupt ends it
    @(posedge clk);
    readyPinIn <= 1'b0;
    busAccess();
    // One idle cycle so the bus word is never assigned twice in a step
    @(posedge clk);
    busIn <= 3'h4;
    pulse(2);
    repeat (4) begin
      @(negedge clk);
      check(16'(cpuHalt), 16'h0000);
    end
    @(posedge clk);
    busIn <= 3'h0;
    @(negedge clk);
    waitFor(3, 1'b1, 4, n);
    check(16'(periphHalt), 16'h0000);
    @(posedge clk);
    intReq <= 1'b1;
    @(negedge clk);
    waitFor(3, 1'b0, 4, n);
    @(posedge clk);
    intReq <= 1'b0;
    // A reset also ends idle
    pulse(2);
    waitFor(3, 1'b1, 4, n);
    pulse(1);
    waitFor(0, 1'b1, 4, n);
    settle(SRC_WDT);
    // Power-down ignores plain interrupts, fast interrupt wakes it
    @(posedge clk);
    pmCfg <= 3'h1;
    pulse(3);
    waitFor(4, 1'b1, 5, n);
    check(16'(cpuHalt), 16'h0001);
    @(posedge clk);
    intReq <= 1'b1;
    repeat (3) @(negedge clk);
    check(16'(periphHalt), 16'h0001);
    @(posedge clk);
    intReq <= 1'b0;
    fastIntReq <= 1'b1;
    @(negedge clk);
    waitFor(4, 1'b0, 5, n);
    @(posedge clk);
    fastIntReq <= 1'b0;
    // Without fast wake only a hardware reset ends power-down
    @(posedge clk);
    pmCfg <= 3'h0;
    pulse(3);
    waitFor(4, 1'b1, 5, n);
    @(posedge clk);
    fastIntReq <= 1'b1;
    repeat (3) @(negedge clk);
    check(16'(periphHalt), 16'h0001);
    @(posedge clk);
    fastIntReq <= 1'b0;
    extLow <= 1'b1;
    repeat (4) @(posedge clk);
    extLow <= 1'b0;
    settle(SRC_WARM);
    end_of_test();
  end
endmodule
